// ==== logic/smc_pkg.sv ====
// Constants, register map and types of the multichannel serial port selection block
// ****************************************************************
// Behaviour
// - Both extended bits set gives independent selection of up to 128 channels.
// - Twelve extra enable registers exist, six receive and six transmit.
// - Extra registers gate partitions C through H, one receive and one transmit each.
// - Each partition spans sixteen channels; partition H holds channels 112 to 127.
// - Receive enable bit n set enables channel n reception; read/write, reset zero.
// - Transmit enable bit n set enables channel n transmission; read/write, reset zero.
// - Clock stop mode is SPI-like, single phase, exactly one word per frame.
// - Word length programmable to 8, 12, 16, 20, 24 or 32 bits.
// - In SPI mode transmitter and receiver are both master or both slave.
// - Port logic is static and works at arbitrarily low serial clock rates.
// - Both extended bits clear gives partitions A and B, 32 channels.
// - Receive extended bit in control register one, transmit in control two.
// ****************************************************************
package smc_pkg;
	localparam int NUM_PART      = 8;
	localparam int PART_CHANS    = 16;
	localparam int NUM_CHANS     = 128;
	localparam int BASIC_CHANS   = 32;
	localparam int MAX_BITS      = 32;

	// Byte offsets of the registers
	localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFS_CONFIG   = 8'h08;
	localparam logic [7:0] OFS_STATUS   = 8'h0c;
	localparam logic [7:0] OFS_RXDATA   = 8'h10;
	localparam logic [7:0] OFS_TXDATA   = 8'h14;
	localparam logic [7:0] OFS_RX_EN    = 8'h40;
	localparam logic [7:0] OFS_TX_EN    = 8'h60;

	// Field positions
	localparam int BIT_EXT       = 9;
	localparam int BIT_CLKSTOP   = 0;
	localparam int BIT_MASTER    = 1;
	localparam int BIT_WLEN_LO   = 4;
	localparam int BIT_ENABLE    = 8;
	localparam int BIT_RX_FULL   = 0;
	localparam int BIT_TX_EMPTY  = 1;

	localparam logic [15:0] ENABLE_RESET = 16'h0000;
	localparam logic [31:0] WORD_RESET   = 32'h0000_0000;

	// Word length codes
	typedef enum logic [2:0] {
		SMC_W8  = 3'h0,
		SMC_W12 = 3'h1,
		SMC_W16 = 3'h2,
		SMC_W20 = 3'h3,
		SMC_W24 = 3'h4,
		SMC_W32 = 3'h5
	} smc_wlen_type;

	function automatic logic [5:0] smc_wlen_bits(input logic [2:0] code);
		case (code)
			3'h0:    smc_wlen_bits = 6'h08;
			3'h1:    smc_wlen_bits = 6'h0c;
			3'h2:    smc_wlen_bits = 6'h10;
			3'h3:    smc_wlen_bits = 6'h14;
			3'h4:    smc_wlen_bits = 6'h18;
			default: smc_wlen_bits = 6'h20;
		endcase
	endfunction
endpackage

// ==== logic/smc_port.sv ====
// Multichannel serial port channel selection, clock stop mode and AHB-Lite registers
`timescale 1ns/1ns
module smc_port
	import smc_pkg::*;
(
	// Bus clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Serial link, bit clock domain
	input  wire logic        bit_clk,
	input  wire logic        frame_sync,
	input  wire logic        rx_data,
	output logic             tx_data,
	output logic             tx_data_oe
);
	// ****************************************************************
	// Register file (bus domain)
	// ****************************************************************
	logic        rx_ext_q, tx_ext_q;
	logic        clkstop_q, master_q, enable_q;
	logic [2:0]  wlen_q;
	logic [31:0] txword_q, rxword_q;
	logic        rx_full_q, tx_empty_q;
	logic [15:0] rx_en_q [NUM_PART];
	logic [15:0] tx_en_q [NUM_PART];
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;

	wire         bus_go    = hsel & hready & htrans[1];
	wire         rd_go     = bus_go & ~hwrite;
	wire [2:0]   w_part    = wr_addr_q[4:2];
	wire         w_rx_en   = wr_pend_q & (wr_addr_q[7:5] == OFS_RX_EN[7:5]);
	wire         w_tx_en   = wr_pend_q & (wr_addr_q[7:5] == OFS_TX_EN[7:5]);
	wire         w_ctrl1   = wr_pend_q & (wr_addr_q == OFS_CTRL_ONE);
	wire         w_ctrl2   = wr_pend_q & (wr_addr_q == OFS_CTRL_TWO);
	wire         w_cfg     = wr_pend_q & (wr_addr_q == OFS_CONFIG);
	wire         w_txd     = wr_pend_q & (wr_addr_q == OFS_TXDATA);
	wire         r_rxd     = rd_go & (haddr == OFS_RXDATA);
	wire [2:0]   r_part    = haddr[4:2];
	// Read word for the address phase
	wire [31:0]  rd_word   =
		(haddr == OFS_CTRL_ONE) ? {22'h0, rx_ext_q, 9'h0} :
		(haddr == OFS_CTRL_TWO) ? {22'h0, tx_ext_q, 9'h0} :
		(haddr == OFS_CONFIG)   ? {23'h0, enable_q, 1'b0, wlen_q, 2'h0, master_q, clkstop_q} :
		(haddr == OFS_STATUS)   ? {30'h0, tx_empty_q, rx_full_q} :
		(haddr == OFS_RXDATA)   ? rxword_q :
		(haddr == OFS_TXDATA)   ? txword_q :
		(haddr[7:5] == OFS_RX_EN[7:5]) ? {16'h0, rx_en_q[r_part]} :
		(haddr[7:5] == OFS_TX_EN[7:5]) ? {16'h0, tx_en_q[r_part]} : 32'h0;

	// Crossing signals
	logic rx_tgl_s, tx_tgl_s;
	logic [2:0] rx_sync_q, tx_sync_q;
	logic [31:0] rx_shadow_s;
	wire rx_evt = rx_sync_q[2] ^ rx_sync_q[1];
	wire tx_evt = tx_sync_q[2] ^ tx_sync_q[1];

	// Address phase capture, zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata    <= WORD_RESET;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend_q <= bus_go & hwrite;
			wr_addr_q <= haddr;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (rd_go) hrdata <= rd_word;
		end
	end

	// Mode and config registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_ext_q  <= 1'b0;
			tx_ext_q  <= 1'b0;
			clkstop_q <= 1'b0;
			master_q  <= 1'b0;
			enable_q  <= 1'b0;
			wlen_q    <= SMC_W8;
			txword_q  <= WORD_RESET;
		end else begin
			if (w_ctrl1) rx_ext_q <= hwdata[BIT_EXT];
			if (w_ctrl2) tx_ext_q <= hwdata[BIT_EXT];
			if (w_cfg) begin
				clkstop_q <= hwdata[BIT_CLKSTOP];
				master_q  <= hwdata[BIT_MASTER];
				enable_q  <= hwdata[BIT_ENABLE];
				wlen_q    <= (hwdata[6:4] > 3'h5) ? SMC_W32 : hwdata[6:4];
			end
			if (w_txd) txword_q <= hwdata;
		end
	end

	// Partition enable registers A..H
	genvar gp;
	for (gp = 0; gp < NUM_PART; gp++) begin : g_part
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				rx_en_q[gp] <= ENABLE_RESET;
				tx_en_q[gp] <= ENABLE_RESET;
			end else begin
				if (w_rx_en && w_part == gp) rx_en_q[gp] <= hwdata[15:0];
				if (w_tx_en && w_part == gp) tx_en_q[gp] <= hwdata[15:0];
			end
		end
	end

	// Status flags: hardware set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_sync_q  <= 3'h0;
			tx_sync_q  <= 3'h0;
			rx_full_q  <= 1'b0;
			tx_empty_q <= 1'b1;
			rxword_q   <= WORD_RESET;
		end else begin
			rx_sync_q <= {rx_sync_q[1:0], rx_tgl_s};
			tx_sync_q <= {tx_sync_q[1:0], tx_tgl_s};
			if (rx_evt) begin
				rx_full_q <= 1'b1;
				rxword_q  <= rx_shadow_s;
			end else if (r_rxd) rx_full_q <= 1'b0;
			if (tx_evt) tx_empty_q <= 1'b1;
			else if (w_txd) tx_empty_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Link logic (bit clock domain, static: only moves on bit_clk edges)
	// ****************************************************************
	// Config is quasi-static: software changes it only with the port disabled
	logic [1:0]  en_s_q;
	logic [6:0]  chan_q;
	logic [5:0]  bit_q;
	logic [31:0] rx_sh_q, tx_sh_q;
	logic        frame_act_q;
	logic        rx_tgl_q, tx_tgl_q;
	logic        tx_data_q, tx_oe_q;
	logic        fs_q;

	wire         ext_mode  = rx_ext_q & tx_ext_q;
	wire [7:0]   max_chan  = clkstop_q ? 8'h01 : (ext_mode ? 8'h80 : 8'h20);
	wire [5:0]   wbits     = smc_wlen_bits(wlen_q);
	wire [2:0]   c_part    = chan_q[6:4];
	wire [3:0]   c_slot    = chan_q[3:0];
	wire         rx_on     = clkstop_q | rx_en_q[c_part][c_slot];
	wire         tx_on     = clkstop_q | tx_en_q[c_part][c_slot];
	wire         last_bit  = (bit_q == wbits - 6'h01);
	wire         last_chan = ({1'b0, chan_q} == max_chan - 8'h01);
	wire         start     = fs_q & en_s_q[1];
	wire [31:0]  rx_next   = {rx_sh_q[30:0], rx_data};

	assign rx_tgl_s    = rx_tgl_q;
	assign tx_tgl_s    = tx_tgl_q;
	assign rx_shadow_s = rx_sh_q;

	// Frame and channel counters and shifting; no time-outs, so arbitrarily low bit clock rates work
	always_ff @(posedge bit_clk or negedge hresetn) begin
		if (!hresetn) begin
			en_s_q      <= 2'h0;
			fs_q        <= 1'b0;
			chan_q      <= 7'h00;
			bit_q       <= 6'h00;
			frame_act_q <= 1'b0;
			rx_sh_q     <= WORD_RESET;
			tx_sh_q     <= WORD_RESET;
			rx_tgl_q    <= 1'b0;
			tx_tgl_q    <= 1'b0;
			tx_data_q   <= 1'b0;
			tx_oe_q     <= 1'b0;
		end else begin
			en_s_q <= {en_s_q[0], enable_q};
			fs_q   <= frame_sync;
			if (start && !frame_act_q) begin
				frame_act_q <= 1'b1;
				chan_q      <= 7'h00;
				bit_q       <= 6'h00;
				tx_sh_q     <= txword_q << (6'h20 - wbits);
				tx_tgl_q    <= ~tx_tgl_q;
			end else if (frame_act_q) begin
				// Master and slave share one frame for both directions
				tx_oe_q   <= tx_on;
				tx_data_q <= tx_sh_q[31];
				tx_sh_q   <= {tx_sh_q[30:0], 1'b0};
				if (rx_on) rx_sh_q <= rx_next;
				bit_q <= last_bit ? 6'h00 : bit_q + 6'h01;
				if (last_bit) begin
					if (rx_on) rx_tgl_q <= ~rx_tgl_q;
					if (last_chan) frame_act_q <= 1'b0;
					else chan_q <= chan_q + 7'h01;
				end
			end else begin
				tx_oe_q <= 1'b0;
			end
		end
	end

	assign tx_data    = tx_data_q;
	assign tx_data_oe = tx_oe_q;
endmodule

// ==== testbench/smc_sva.sv ====
// Checker of bus answers, enable read-back and link idle state
`timescale 1ns/1ns
module smc_sva (
	// Bus side
	input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic [31:0] hwdata, hrdata,
	// Link side
	input wire logic        bit_clk, tx_data_oe
);
	// Taken transfers and enable register decode
	wire tk = hsel && hready && htrans[1];
	wire rd = tk && !hwrite;
	wire en_reg = haddr[7:6] == 2'h1 && haddr[1:0] == 2'h0;
	sequence s_wr; tk && hwrite && en_reg; endsequence
	sequence s_rd; rd && haddr == $past(haddr, 2); endsequence
	property p_rdy; @(posedge hclk) disable iff (!hresetn) hreadyout; endproperty
	property p_okay; @(posedge hclk) disable iff (!hresetn) !hresp; endproperty
	property p_rst; @(posedge hclk) disable iff (!hresetn) $rose(hresetn) |-> hrdata == 32'h0; endproperty
	property p_rw; @(posedge hclk) disable iff (!hresetn)
		s_wr ##2 s_rd |=> hrdata == {16'h0, $past(hwdata[15:0], 2)}; endproperty
	property p_upper; @(posedge hclk) disable iff (!hresetn) rd && en_reg |=> hrdata[31:16] == 16'h0; endproperty
	property p_unmap; @(posedge hclk) disable iff (!hresetn) rd && haddr[7] |=> hrdata == 32'h0; endproperty
	property p_hold; @(posedge hclk) disable iff (!hresetn) !rd |=> $stable(hrdata); endproperty
	property p_link; @(posedge bit_clk) disable iff (!hresetn) $rose(hresetn) |-> !tx_data_oe; endproperty
	a_rdy: assert property (p_rdy) else $error("ready low");
	a_okay: assert property (p_okay) else $error("error response");
	a_rst: assert property (p_rst) else $error("read data not clear after reset");
	a_rw: assert property (p_rw) else $error("enable read-back wrong");
	a_upper: assert property (p_upper) else $error("enable upper half not zero");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_link: assert property (p_link) else $error("line driven after reset");
endmodule
bind smc_port smc_sva i_sva (.hclk, .hresetn, .hsel, .hwrite, .hready, .hreadyout, .hresp, .haddr, .htrans,
	.hwdata, .hrdata, .bit_clk, .tx_data_oe);

// ==== testbench/smc_framer.sv ====
// Far-end framer model: bit clock, frame sync and data in, driven bits counted
`timescale 1ns/1ns
module smc_framer (
	// Link
	output logic      bit_clk,
	output logic      frame_sync,
	output logic      rx_data,
	input wire logic  tx_data,
	input wire logic  tx_data_oe
);
	int n_oe;
	logic [31:0] tx_word;
	initial begin
		bit_clk = 0;
		frame_sync = 0;
		rx_data = 0;
	end
	// Collect driven bits at the quiet edge, newest in bit 0
	always @(negedge bit_clk) begin
		if (tx_data_oe) begin
			n_oe++;
			tx_word = {tx_word[30:0], tx_data};
		end
	end
	// Lead clocks, sync, n bits repeating w MSB first, tail clocks; clock still outside
	// Sync stands two edges ahead: one edge to register it, one edge to start the frame
	task automatic frame(input int n, input logic [31:0] w, input int wb, input int lo);
		for (int i = -4; i < n + 3; i++) begin
			frame_sync <= (i == -2);
			rx_data <= (i >= 0 && i < n) ? w[wb - 1 - (i % wb)] : ~rx_data;
			#16 bit_clk = 1;
			#(lo) bit_clk = 0;
		end
	endtask
endmodule

// ==== testbench/tb_serial_port_multichannel_select.sv ====
// Testbench of the serial port channel selection block
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module tb_serial_port_multichannel_select;
	import smc_pkg::*;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [7:0]  haddr = 0;
	logic [31:0] hwdata = 0, rd_q, wd;
	wire  [31:0] hrdata;
	wire         hready, hresp, bit_clk, frame_sync, rx_data, tx_data, tx_data_oe;
	int          fail_count, n_compared, n, wb;
	logic [15:0] en [16];
	always #10 hclk = ~hclk;
	smc_port i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout(hready), .hresp, .bit_clk, .frame_sync, .rx_data, .tx_data, .tx_data_oe);
	smc_framer i_far (.bit_clk, .frame_sync, .rx_data, .tx_data, .tx_data_oe);
	// One single word transfer, read data kept in rd_q
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		do @(posedge hclk); while (!hready);
		hsel <= 0;
		htrans <= 0;
		if (wr) hwdata <= d;
		do @(posedge hclk); while (!hready);
		rd_q = hrdata;
	endtask
	// Driven bit count over the partitions that the mode uses
	function automatic int exp_bits(input bit ext, input int w);
		int s = 0;
		for (int p = 0; p < (ext ? NUM_PART : 2); p++) s += $countones(en[8 + p]) * w;
		return s;
	endfunction
	function automatic logic [31:0] cfg(input int c, input bit e, input bit s);
		return (32'(c) << BIT_WLEN_LO) | (32'(e) << BIT_ENABLE) | (32'(s) << BIT_CLKSTOP);
	endfunction
	task automatic close_out;
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog
	initial begin
		#1200000;
		fail_count++;
		close_out();
	end
	// Main sequence
	initial begin
		void'($urandom(96));
		repeat (20) @(posedge hclk);
		hresetn <= 1;
		for (int i = 0; i < 16; i++) begin
			bus(0, 8'h40 + 8'(4 * i), 0);
			`CHK(rd_q, 32'h0)
			wd = $urandom;
			en[i] = wd[15:0];
			bus(1, 8'h40 + 8'(4 * i), wd);
			bus(0, 8'h40 + 8'(4 * i), 0);
			`CHK(rd_q, {16'h0, en[i]})
		end
		bus(1, 8'h80, 32'hffff_ffff);
		bus(0, 8'h80, 0);
		`CHK(rd_q, 32'h0)
		$display("Register test done");
		// Every word length in 32-channel mode, short ones in 128-channel mode too
		for (int c = 0; c < 6; c++) begin
			for (int x = 0; x < 2; x++) begin
				if (!x || c < 2) begin
					wb = c < 5 ? 8 + 4 * c : 32;
					bus(1, OFS_CONFIG, cfg(c, 0, 0));
					bus(1, OFS_CTRL_ONE, 32'(x) << BIT_EXT);
					bus(1, OFS_CTRL_TWO, 32'(x) << BIT_EXT);
					bus(1, OFS_CONFIG, cfg(c, 1, 0));
					repeat (4) @(posedge hclk);
					n = i_far.n_oe;
					i_far.frame((x ? NUM_CHANS : BASIC_CHANS) * wb, $urandom, wb, x ? 96 : 16);
					@(posedge hclk);
					`CHK(i_far.n_oe - n, exp_bits(x, wb))
				end
			end
		end
		$display("Channel test done");
		// One word in clock stop mode with a slow bit clock
		wd = $urandom;
		n = $urandom;
		bus(1, OFS_CONFIG, cfg(5, 0, 1));
		bus(1, OFS_TXDATA, wd);
		bus(1, OFS_CONFIG, cfg(5, 1, 1));
		repeat (4) @(posedge hclk);
		i_far.frame(32, n, 32, 400);
		repeat (4) @(posedge hclk);
		`CHK(i_far.tx_word, wd)
		bus(0, OFS_STATUS, 0);
		`CHK(rd_q[BIT_RX_FULL], 1'b1)
		bus(0, OFS_RXDATA, 0);
		`CHK(rd_q, 32'(n))
		bus(0, OFS_STATUS, 0);
		`CHK(rd_q[BIT_RX_FULL], 1'b0)
		$display("Clock stop test done");
		close_out();
	end
endmodule
